/* src/sfp_pkg.sv */
// shared types, sizes and helpers for the store forward / prefetch unit
// assumes a single core clock domain and byte addressing
`default_nettype none
package sfp_pkg;

  // ==========================================================
  // sizes
  localparam int ADDR_W     = 32;
  localparam int DATA_W     = 64;
  localparam int SB_DEPTH   = 4;
  localparam int PF_SLOTS   = 6;
  localparam int LINE_BYTES = 64;
  localparam int LINE_OFS_W = $clog2(LINE_BYTES);
  localparam int LINE_W     = ADDR_W - LINE_OFS_W;

  // ==========================================================
  // operand size codes, log2 of the byte count
  typedef enum logic [1:0]
  {
    SZ_BYTE  = 2'h0,
    SZ_WORD  = 2'h1,
    SZ_DWORD = 2'h2,
    SZ_QWORD = 2'h3
  } sfp_size_t;

  typedef struct packed
  {
    logic [ADDR_W-1:0] addr;
    sfp_size_t         size;
    logic [DATA_W-1:0] data;
    logic              high_byte;
  } sfp_store_t;

  typedef struct packed
  {
    logic [ADDR_W-1:0] addr;
    sfp_size_t         size;
  } sfp_load_t;

  typedef struct packed
  {
    logic [ADDR_W-1:0] addr;
    sfp_size_t         size;
    logic [DATA_W-1:0] data;
  } sfp_cache_wr_t;

  typedef struct packed
  {
    logic [LINE_W-1:0] line;
    logic              write_intent;
  } sfp_pf_req_t;

  typedef struct packed
  {
    logic [LINE_W-1:0] line;
    logic              modified;
  } sfp_fill_t;

  // ==========================================================
  // helpers
  function automatic logic [3:0] sfp_bytes(input sfp_size_t sz);
    return 4'h1 << sz;
  endfunction

  // natural alignment: low address bits below the size are zero
  function automatic logic sfp_aligned(input logic [ADDR_W-1:0] a,
                                       input sfp_size_t sz);
    logic [2:0] m;
    m = 3'(sfp_bytes(sz) - 4'h1);
    return (a[2:0] & m) == 3'h0;
  endfunction

endpackage
`default_nettype wire

/* src/sfp_store_buf.sv */
// store buffer: in-order queue of stores, drains to the data cache
// assumes retire pulses arrive in program order, one per store
`timescale 1ns/1ps
`default_nettype none
module sfp_store_buf
  import sfp_pkg::*;
(
  // clock and reset
  input  wire logic                 clk_in,
  input  wire logic                 rst_n_in,
  // store issue and retirement
  input  wire logic                 st_valid_in,
  input  wire sfp_pkg::sfp_store_t  st_in,
  input  wire logic                 retire_in,
  output logic                      st_ready_out,
  // lookups
  input  wire sfp_pkg::sfp_load_t   ld_in,
  input  wire logic [LINE_W-1:0]    pf_line_in,
  output logic                      hit_out,
  output sfp_pkg::sfp_store_t       hit_ent_out,
  output logic                      pf_block_out,
  // data cache write
  output logic                      wr_valid_out,
  output sfp_pkg::sfp_cache_wr_t    wr_out
);
  typedef struct packed
  {
    sfp_store_t [SB_DEPTH-1:0] ent;
    logic [1:0]                head;
    logic [1:0]                tail;
    logic [2:0]                count;
    logic [2:0]                ccount;
    logic                      ready;
    logic                      wr_valid;
    sfp_cache_wr_t             wr;
  } sfp_sb_state_t;

  sfp_sb_state_t      s;
  sfp_sb_state_t      next_s;
  logic [SB_DEPTH-1:0] ovl;
  logic [SB_DEPTH-1:0] same_line;
  logic [ADDR_W:0]     l_end;

  assign l_end = {1'b0, ld_in.addr} + (ADDR_W+1)'(sfp_bytes(ld_in.size));

  // ==========================================================
  // per entry compare, only live entries take part
  for (genvar i = 0; i < SB_DEPTH; i++)
  begin : g_ent
    logic [1:0]      age;
    logic            live;
    logic [ADDR_W:0] s_end;
    assign age   = 2'(i) - s.head;
    assign live  = {1'b0, age} < s.count;
    assign s_end = {1'b0, s.ent[i].addr}
                 + (ADDR_W+1)'(sfp_bytes(s.ent[i].size));
    assign ovl[i] = live && ({1'b0, s.ent[i].addr} < l_end)
                  && ({1'b0, ld_in.addr} < s_end);
    assign same_line[i] = live
      && s.ent[i].addr[ADDR_W-1:LINE_OFS_W] == pf_line_in; // R4
  end

  // ==========================================================
  // walk oldest to youngest so the youngest overlap wins
  always_comb
  begin
    logic [1:0] idx;
    idx = 2'h0;
    hit_out = 1'b0;
    hit_ent_out = s.ent[s.head];
    for (int k = 0; k < SB_DEPTH; k++)
    begin
      idx = s.head + 2'(k);
      if (3'(k) < s.count && ovl[idx])
      begin
        hit_out = 1'b1;
        hit_ent_out = s.ent[idx]; // R16
      end
    end
  end

  assign pf_block_out = |same_line;
  assign st_ready_out = s.ready;
  assign wr_valid_out = s.wr_valid;
  assign wr_out       = s.wr;

  // ==========================================================
  // queue update; only retired stores may drain
  always_comb
  begin
    logic push;
    logic pop;
    logic ret;
    next_s = s;
    push = st_valid_in && s.ready;
    pop  = s.ccount != 3'h0; // R12
    ret  = retire_in && s.count > s.ccount;
    next_s.wr_valid = pop;
    if (pop)
    begin
      next_s.wr = '{s.ent[s.head].addr, s.ent[s.head].size,
                    s.ent[s.head].data};
      next_s.head = s.head + 2'h1;
    end
    if (push)
    begin
      next_s.ent[s.tail] = st_in;
      next_s.tail = s.tail + 2'h1;
    end
    next_s.count  = 3'(s.count + {2'h0, push} - {2'h0, pop});
    next_s.ccount = 3'(s.ccount + {2'h0, ret} - {2'h0, pop});
    next_s.ready  = next_s.count != 3'(SB_DEPTH);
  end

  // state register
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      s <= '0;
      s.ready <= 1'b1;
    end
    else
      s <= next_s;
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  property p_r12;
    wr_valid_out |-> $past(s.ccount) != 3'h0;
  endproperty
  a_r12: assert property (p_r12) // R12
    else $error("store drained before retirement");

endmodule
`default_nettype wire

/* src/sfp_pf_queue.sv */
// prefetch queue: six in-order slots, each one memory line read
// assumes memory returns fills in the order the reads were sent
`timescale 1ns/1ps
`default_nettype none
module sfp_pf_queue
  import sfp_pkg::*;
(
  // clock and reset
  input  wire logic                  clk_in,
  input  wire logic                  rst_n_in,
  // hints from the core
  input  wire logic                  hint_valid_in,
  input  wire sfp_pkg::sfp_pf_req_t  hint_in,
  output logic                       drop_out,
  // store conflict check
  output logic [LINE_W-1:0]          pf_line_out,
  input  wire logic                  block_in,
  // memory side
  output logic                       mem_valid_out,
  output sfp_pkg::sfp_pf_req_t       mem_out,
  input  wire logic                  fill_valid_in,
  output logic                       inst_valid_out,
  output sfp_pkg::sfp_fill_t         inst_out
);
  typedef struct packed
  {
    sfp_pf_req_t [PF_SLOTS-1:0] slot;
    logic [2:0]  head;
    logic [2:0]  iss;
    logic [2:0]  tail;
    logic [2:0]  count;
    logic [2:0]  pend;
    logic [2:0]  outst;
    logic        drop;
    logic        mem_valid;
    sfp_pf_req_t mem;
    logic        inst_valid;
    sfp_fill_t   inst;
  } sfp_pq_state_t;

  sfp_pq_state_t s;
  sfp_pq_state_t next_s;

  function automatic logic [2:0] inc6(input logic [2:0] p);
    return (p == 3'(PF_SLOTS - 1)) ? 3'h0 : p + 3'h1;
  endfunction

  assign pf_line_out    = s.slot[s.iss].line;
  assign drop_out       = s.drop;
  assign mem_valid_out  = s.mem_valid;
  assign mem_out        = s.mem;
  assign inst_valid_out = s.inst_valid;
  assign inst_out       = s.inst;

  // ==========================================================
  // accept, issue in order, retire on fill
  always_comb
  begin
    logic acc;
    logic iss;
    logic fill;
    next_s = s;
    fill = fill_valid_in && s.outst != 3'h0;
    acc  = hint_valid_in && (s.count != 3'(PF_SLOTS) || fill); // R2
    iss  = s.pend != 3'h0 && !block_in; // R4
    next_s.drop = hint_valid_in && !acc; // R2
    next_s.mem_valid = iss;
    next_s.inst_valid = fill;
    if (iss)
    begin
      next_s.mem = s.slot[s.iss];
      next_s.iss = inc6(s.iss);
    end
    if (fill)
    begin
      next_s.inst = '{s.slot[s.head].line,
                      s.slot[s.head].write_intent}; // R3
      next_s.head = inc6(s.head);
    end
    if (acc)
    begin
      next_s.slot[s.tail] = hint_in;
      next_s.tail = inc6(s.tail);
    end
    next_s.count = 3'(s.count + {2'h0, acc} - {2'h0, fill});
    next_s.pend  = 3'(s.pend + {2'h0, acc} - {2'h0, iss});
    next_s.outst = 3'(s.outst + {2'h0, iss} - {2'h0, fill}); // R1
  end

  // state register
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      s <= '0;
    else
      s <= next_s;
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  property p_r1;
    s.outst <= 3'(PF_SLOTS);
  endproperty
  a_r1: assert property (p_r1) // R1
    else $error("more than six prefetches outstanding");

  property p_r2;
    hint_valid_in && s.count == 3'(PF_SLOTS) && !fill_valid_in
      |=> drop_out && $stable(s.tail);
  endproperty
  a_r2: assert property (p_r2) // R2
    else $error("hint not dropped with all slots busy");

  property p_r3;
    fill_valid_in && s.outst != 3'h0
      |=> inst_valid_out
      && inst_out.modified == $past(s.slot[s.head].write_intent);
  endproperty
  a_r3: assert property (p_r3) // R3
    else $error("install state does not follow write intent");

  property p_r4;
    block_in |=> !mem_valid_out;
  endproperty
  a_r4: assert property (p_r4) // R4
    else $error("prefetch issued over a pending store");

endmodule
`default_nettype wire

/* src/sfp_top.sv */
// load/store side: store buffer with load forwarding and prefetch queue
// assumes stores older than a load are issued at least a cycle earlier
// Behaviour
// (R1) At most six prefetch reads are outstanding to memory at once.
// (R2) With six prefetches held, new hints drop until a slot frees.
// (R3) A write intent prefetch installs its line in modified state.
// (R4) A prefetch waits while a buffered store hits its line.
// (R5) Prefetch and fill move whole 64 byte lines.
// (R6) A data cache write casts the same line out of the code cache.
// (R7) A load forwards only from a store with the same start address.
// (R8) A load forwards only if it is no wider than the store.
// (R9) No forwarding when the load or the store is misaligned.
// (R10) A store of upper byte register data never forwards.
// (R11) A refused load stalls until the store has reached the cache.
// (R12) A store writes the cache only after it has retired.
// (R13) A narrow store inside a wider load makes the load wait.
// (R14) A wider store at another start address makes the load wait.
// (R15) A dword load on an aligned qword store gets its low 32 bits.
// (R16) The youngest overlapping older store decides forwarding.
`timescale 1ns/1ps
`default_nettype none
module sfp_top
  import sfp_pkg::*;
(
  // clock and reset
  input  wire logic                   CLK_SYS_IN,
  input  wire logic                   RSTN_IN,
  // store issue and retirement
  input  wire logic                   ST_VALID_IN,
  input  wire sfp_pkg::sfp_store_t    ST_IN,
  output logic                        ST_READY_OUT,
  input  wire logic                   RETIRE_IN,
  // load request and answer
  input  wire logic                   LD_VALID_IN,
  input  wire sfp_pkg::sfp_load_t     LD_IN,
  output logic                        LD_READY_OUT,
  output logic                        LD_DONE_OUT,
  output logic                        LD_FWD_OUT,
  output logic [sfp_pkg::DATA_W-1:0]  LD_DATA_OUT,
  // data cache write and code cache castout
  output logic                        DC_WR_VALID_OUT,
  output sfp_pkg::sfp_cache_wr_t      DC_WR_OUT,
  output logic                        IC_CASTOUT_VALID_OUT,
  output logic [sfp_pkg::LINE_W-1:0]  IC_CASTOUT_LINE_OUT,
  // prefetch hints
  input  wire logic                   PF_HINT_VALID_IN,
  input  wire sfp_pkg::sfp_pf_req_t   PF_HINT_IN,
  output logic                        PF_DROP_OUT,
  // memory line reads and fills
  output logic                        MEM_RD_VALID_OUT,
  output sfp_pkg::sfp_pf_req_t        MEM_RD_OUT,
  input  wire logic                   FILL_VALID_IN,
  output logic                        INSTALL_VALID_OUT,
  output sfp_pkg::sfp_fill_t          INSTALL_OUT
);
  import sfp_pkg::*;

  // ==========================================================
  // types and state
  typedef enum logic [1:0]
  {
    LS_IDLE  = 2'b01,
    LS_STALL = 2'b10
  } sfp_ld_state_t;

  typedef struct packed
  {
    sfp_ld_state_t      fsm;
    sfp_load_t          ld;
    logic               ld_ready;
    logic               ld_done;
    logic               ld_fwd;
    logic [DATA_W-1:0]  ld_data;
  } sfp_top_state_t;

  sfp_top_state_t     s;
  sfp_top_state_t     next_s;
  logic [1:0]         rst_sync;
  logic               rst_n;

  sfp_load_t          cur_ld;
  logic               active;
  logic               hit;
  sfp_store_t         hit_ent;
  logic               pf_block;
  logic [LINE_W-1:0]  pf_line;
  logic               sb_wr_valid;
  sfp_cache_wr_t      sb_wr;

  logic               addr_eq;
  logic               size_ok;
  logic               align_ok;
  logic               src_ok;
  logic               fwd_ok;
  logic [DATA_W-1:0]  fwd_data;

  // ==========================================================
  // reset release; assertion is immediate, release is clocked
  always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
      rst_sync <= 2'h0;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end

  assign rst_n = rst_sync[1];

  // ==========================================================
  // store buffer
  sfp_store_buf u_sfp_store_buf
  (
    .clk_in       (CLK_SYS_IN),
    .rst_n_in     (rst_n),
    .st_valid_in  (ST_VALID_IN),
    .st_in        (ST_IN),
    .retire_in    (RETIRE_IN),
    .st_ready_out (ST_READY_OUT),
    .ld_in        (cur_ld),
    .pf_line_in   (pf_line),
    .hit_out      (hit),
    .hit_ent_out  (hit_ent),
    .pf_block_out (pf_block),
    .wr_valid_out (sb_wr_valid),
    .wr_out       (sb_wr)
  );

  // ==========================================================
  // prefetch queue
  sfp_pf_queue u_sfp_pf_queue
  (
    .clk_in         (CLK_SYS_IN),
    .rst_n_in       (rst_n),
    .hint_valid_in  (PF_HINT_VALID_IN),
    .hint_in        (PF_HINT_IN),
    .drop_out       (PF_DROP_OUT),
    .pf_line_out    (pf_line),
    .block_in       (pf_block),
    .mem_valid_out  (MEM_RD_VALID_OUT),
    .mem_out        (MEM_RD_OUT),
    .fill_valid_in  (FILL_VALID_IN),
    .inst_valid_out (INSTALL_VALID_OUT),
    .inst_out       (INSTALL_OUT)
  );

  // ==========================================================
  // cache write and castout share the drain flop, so the code
  // cache sees the castout in the same cycle the data lands
  assign DC_WR_VALID_OUT      = sb_wr_valid;
  assign DC_WR_OUT            = sb_wr;
  assign IC_CASTOUT_VALID_OUT = sb_wr_valid; // R6
  assign IC_CASTOUT_LINE_OUT  =
    sb_wr.addr[ADDR_W-1:LINE_OFS_W]; // R5

  assign LD_READY_OUT = s.ld_ready;
  assign LD_DONE_OUT  = s.ld_done;
  assign LD_FWD_OUT   = s.ld_fwd;
  assign LD_DATA_OUT  = s.ld_data;

  // ==========================================================
  // load under test: a new request, or the one held in a stall
  always_comb
  begin
    cur_ld = s.ld;
    active = 1'b0;
    if (s.fsm == LS_STALL)
      active = 1'b1;
    else if (LD_VALID_IN && s.ld_ready)
    begin
      cur_ld = LD_IN;
      active = 1'b1;
    end
  end

  // ==========================================================
  // forwarding conditions against the youngest overlapping store;
  // partial overlaps fall out as a start or size mismatch
  assign addr_eq  = cur_ld.addr == hit_ent.addr; // R7 R14
  assign size_ok  = cur_ld.size <= hit_ent.size; // R8 R13
  assign align_ok = sfp_aligned(cur_ld.addr, cur_ld.size)
                 && sfp_aligned(hit_ent.addr, hit_ent.size); // R9
  assign src_ok   = !hit_ent.high_byte; // R10
  assign fwd_ok   = addr_eq && size_ok && align_ok && src_ok;

  // same start address, so the load takes the low bytes
  always_comb
  begin
    case (cur_ld.size)
      SZ_BYTE:  fwd_data = {56'h0, hit_ent.data[7:0]};
      SZ_WORD:  fwd_data = {48'h0, hit_ent.data[15:0]};
      SZ_DWORD: fwd_data = {32'h0, hit_ent.data[31:0]}; // R15
      SZ_QWORD: fwd_data = hit_ent.data;
      default:  fwd_data = hit_ent.data;
    endcase
  end

  // ==========================================================
  // load sequencer; a stall re-checks every cycle and ends once
  // the blocking store has drained out of the buffer
  always_comb
  begin
    next_s = s;
    next_s.ld_done = 1'b0;
    next_s.ld_fwd  = 1'b0;
    case (s.fsm)
      LS_IDLE,
      LS_STALL:
      begin
        if (active)
        begin
          next_s.ld = cur_ld;
          if (!hit)
          begin
            next_s.fsm     = LS_IDLE;
            next_s.ld_done = 1'b1;
            next_s.ld_data = '0;
          end
          else if (fwd_ok)
          begin
            next_s.fsm     = LS_IDLE;
            next_s.ld_done = 1'b1;
            next_s.ld_fwd  = 1'b1;
            next_s.ld_data = fwd_data;
          end
          else
            next_s.fsm = LS_STALL; // R11
        end
      end
      default:
        next_s.fsm = LS_IDLE;
    endcase
    next_s.ld_ready = next_s.fsm == LS_IDLE;
  end

  // state register
  always_ff @(posedge CLK_SYS_IN or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s <= '0;
      s.fsm <= LS_IDLE;
      s.ld_ready <= 1'b1;
    end
    else
      s <= next_s;
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!rst_n);

  property p_r7;
    active && hit && !addr_eq |=> !LD_FWD_OUT;
  endproperty
  a_r7: assert property (p_r7) // R7
    else $error("forwarded across different start addresses");

  property p_r8;
    active && hit && cur_ld.size > hit_ent.size
      |=> !LD_DONE_OUT && !LD_READY_OUT;
  endproperty
  a_r8: assert property (p_r8) // R8
    else $error("wide load took narrow store data");

  property p_r9;
    active && hit && !align_ok |=> !LD_FWD_OUT;
  endproperty
  a_r9: assert property (p_r9) // R9
    else $error("forwarded on a misaligned access");

  property p_r10;
    active && hit && hit_ent.high_byte |=> !LD_FWD_OUT;
  endproperty
  a_r10: assert property (p_r10) // R10
    else $error("forwarded upper byte register data");

  property p_r11;
    active && hit && !fwd_ok
      |=> s.fsm == LS_STALL && !LD_DONE_OUT;
  endproperty
  a_r11: assert property (p_r11) // R11
    else $error("refused load did not stall");

  property p_r14;
    active && hit && hit_ent.size > cur_ld.size && !addr_eq
      |=> !LD_DONE_OUT ##1 !LD_FWD_OUT;
  endproperty
  a_r14: assert property (p_r14) // R14
    else $error("wide store forwarded to offset load");

  property p_r15;
    active && hit && fwd_ok && cur_ld.size == SZ_DWORD
      && hit_ent.size == SZ_QWORD
      |=> LD_FWD_OUT && LD_DATA_OUT == {32'h0, $past(hit_ent.data[31:0])};
  endproperty
  a_r15: assert property (p_r15) // R15
    else $error("dword from qword store not forwarded");

  property p_r6;
    DC_WR_VALID_OUT |-> IC_CASTOUT_VALID_OUT
      && IC_CASTOUT_LINE_OUT == DC_WR_OUT.addr[ADDR_W-1:LINE_OFS_W];
  endproperty
  a_r6: assert property (p_r6) // R6
    else $error("data write without matching code castout");

endmodule
`default_nettype wire

/* verif/sfp_mem_model.sv */
// memory model behind the prefetch queue's line reads
// assumes reads arrive one per cycle and are answered in order
`timescale 1ns/1ps
`default_nettype none
module sfp_mem_model
(
  // clock and reset
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  // line reads and fills
  input  wire logic rd_valid_in,
  input  wire logic hold_in,
  output logic      fill_valid_out
);
  // ==========================================================
  // outstanding reads
  int   pend;
  logic go;

  // at most one fill every other cycle, so the queue sees gaps;
  // hold_in stalls memory so the queue can be filled up
  always @(posedge clk_in or negedge rst_n_in)
    if (!rst_n_in)
    begin
      pend = 0;
      fill_valid_out <= 1'b0;
    end
    else
    begin
      go = !hold_in && !fill_valid_out && pend > 0;
      fill_valid_out <= go;
      pend = pend + int'(rd_valid_in) - int'(go);
    end
endmodule
`default_nettype wire

/* verif/store_forward_prefetch_unit_tb.sv */
// self-checking bench for the load/store forwarding and prefetch unit
// assumes sfp_top and the memory model; notes queued, monitor compares
`timescale 1ns/1ps
`default_nettype none
module store_forward_prefetch_unit_tb;
  import sfp_pkg::*;
  // ==========================================================
  // stimulus and observed signals
  logic clk = 1'b0, rst_n = 1'b0, st_v = 1'b0, ld_v = 1'b0;
  logic ret = 1'b0, hv = 1'b0, hold = 1'b0;
  sfp_store_t  st = '0;
  sfp_load_t   ld = '0;
  sfp_pf_req_t hint = '0, rd;
  logic st_rdy, ld_rdy, ld_done, ld_fwd, dc_v, ic_v, drop, rd_v, fill_v, in_v;
  logic [DATA_W-1:0] ld_data;
  logic [LINE_W-1:0] ic_line;
  sfp_cache_wr_t dc;
  sfp_fill_t inst;
  int bad_count = 0, n_checks = 0, cyc = 0, seed = 56;
  int n_done = 0, n_dc = 0, n_rd = 0, n_drop = 0, n_f = 0;
  logic [DATA_W:0] q_ld[$];
  sfp_cache_wr_t q_dc[$];
  sfp_pf_req_t q_pf[$], q_in[$];
  // {st size, st ofs, high byte, ld size, ld ofs, forwards}
  localparam logic [11:0] CASES [10] = '{12'hc31, 12'hc21, 12'h001,
    12'h420, 12'h1a0, 12'h814, 12'he38, 12'h801, 12'h040, 12'h482};

  always #2.5 clk = ~clk;

  sfp_top u_sfp_top (.CLK_SYS_IN(clk), .RSTN_IN(rst_n),
    .ST_VALID_IN(st_v), .ST_IN(st), .ST_READY_OUT(st_rdy),
    .RETIRE_IN(ret), .LD_VALID_IN(ld_v), .LD_IN(ld),
    .LD_READY_OUT(ld_rdy), .LD_DONE_OUT(ld_done), .LD_FWD_OUT(ld_fwd),
    .LD_DATA_OUT(ld_data), .DC_WR_VALID_OUT(dc_v), .DC_WR_OUT(dc),
    .IC_CASTOUT_VALID_OUT(ic_v), .IC_CASTOUT_LINE_OUT(ic_line),
    .PF_HINT_VALID_IN(hv), .PF_HINT_IN(hint), .PF_DROP_OUT(drop),
    .MEM_RD_VALID_OUT(rd_v), .MEM_RD_OUT(rd), .FILL_VALID_IN(fill_v),
    .INSTALL_VALID_OUT(in_v), .INSTALL_OUT(inst));

  sfp_mem_model u_sfp_mem_model (.clk_in(clk), .rst_n_in(rst_n),
    .rd_valid_in(rd_v), .hold_in(hold), .fill_valid_out(fill_v));

  // ==========================================================
  // compare and close
  task automatic chk(input string nm, input logic [127:0] e,
                     input logic [127:0] s);
    n_checks++;
    if (s !== e)
    begin
      bad_count++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask

  task automatic end_sim();
    if (bad_count == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // hang guard, well above the few hundred cycles the run needs
  always @(posedge clk)
    if (++cyc == 3000)
    begin
      bad_count++;
      end_sim();
    end

  // monitor: oldest note is taken off whenever a result appears
  always @(posedge clk)
  begin
    if (ld_done)
    begin
      n_done++;
      chk("ld", q_ld.pop_front(), {ld_fwd, ld_data});
    end
    if (dc_v)
    begin
      n_dc++;
      chk("dc", q_dc[0], dc);
      chk("ic", {1'b1, q_dc[0].addr[31:6]}, {ic_v, ic_line});
      void'(q_dc.pop_front());
    end
    if (rd_v)
    begin
      n_rd++;
      chk("rd", q_pf.pop_front(), rd);
      chk("nout", 1'b1, n_rd - n_f <= PF_SLOTS);
    end
    if (in_v)
      chk("inst", q_in.pop_front(), inst);
    n_f += int'(fill_v);
    n_drop += int'(drop);
  end

  // ==========================================================
  // bus tasks
  task automatic do_st(input sfp_store_t s);
    @(posedge clk);
    st <= s;
    st_v <= 1'b1;
    q_dc.push_back('{s.addr, s.size, s.data});
    @(posedge clk);
    st_v <= 1'b0;
  endtask

  task automatic do_ret();
    @(posedge clk);
    ret <= 1'b1;
    @(posedge clk);
    ret <= 1'b0;
  endtask

  // optional older store o, then store s, then load l
  task automatic fcase(input sfp_store_t s, input sfp_load_t l,
                       input logic fwd, input logic two,
                       input sfp_store_t o);
    logic [DATA_W-1:0] m;
    int d0, c0, k;
    m = (l.size == SZ_QWORD) ? '1 : (64'h1 << (8 << l.size)) - 64'h1;
    d0 = n_done;
    c0 = n_dc;
    if (two)
      do_st(o);
    do_st(s);
    @(posedge clk);
    ld <= l;
    ld_v <= 1'b1;
    q_ld.push_back({fwd, fwd ? s.data & m : 64'h0});
    @(posedge clk);
    ld_v <= 1'b0;
    if (!fwd)
    begin
      repeat (4) @(posedge clk);
      chk("stall", {d0, 1'b0}, {n_done, ld_rdy});
      chk("nodc", c0, n_dc);
    end
    repeat (1 + two) do_ret();
    for (k = 0; k < 50 && n_done <= d0; k++) @(posedge clk);
    repeat (3) @(posedge clk);
    chk("cnt", {d0 + 1, c0 + 1 + two}, {n_done, n_dc});
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    int i, r0;
    logic [11:0] c;
    logic [31:0] a;
    sfp_store_t s, o;
    sfp_load_t l;
    sfp_pf_req_t h;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    // forwarding table, random data and line
    for (i = 0; i < 10; i++)
    begin
      c = CASES[i];
      a = 32'h0001_0000 | ($random(seed) & 32'h0fc0);
      s = '{a + c[9:7], sfp_size_t'(c[11:10]),
            {$random(seed), $random(seed)}, c[6]};
      l = '{a + c[3:1], sfp_size_t'(c[5:4])};
      fcase(s, l, c[0], 1'b0, s);
    end
    // two matching stores: only the younger one counts
    for (i = 0; i < 2; i++)
    begin
      o = '{a, SZ_QWORD, {$random(seed), $random(seed)}, !i[0]};
      s = '{a, SZ_BYTE, {$random(seed), $random(seed)}, i[0]};
      fcase(s, '{a, SZ_BYTE}, !i[0], 1'b1, o);
    end
    // seven hints against stalled memory: six go out, one drops
    @(posedge clk);
    hold <= 1'b1;
    for (i = 0; i < 7; i++)
    begin
      h = '{26'($random(seed)), 1'($random(seed))};
      if (i < PF_SLOTS)
      begin
        q_pf.push_back(h);
        q_in.push_back(h);
      end
      hint <= h;
      hv <= 1'b1;
      @(posedge clk);
    end
    hv <= 1'b0;
    repeat (10) @(posedge clk);
    chk("full", {32'd6, 32'd1}, {n_rd, n_drop});
    hold <= 1'b0;
    for (i = 0; i < 60 && n_f < 6; i++) @(posedge clk);
    repeat (3) @(posedge clk);
    chk("inst", 0, q_in.size());
    // hint to the line of a buffered store waits for the drain
    s = '{a + 32'h8, SZ_QWORD, {$random(seed), $random(seed)}, 1'b0};
    do_st(s);
    h = '{s.addr[31:6], 1'b1};
    q_pf.push_back(h);
    q_in.push_back(h);
    r0 = n_rd;
    @(posedge clk);
    hint <= h;
    hv <= 1'b1;
    @(posedge clk);
    hv <= 1'b0;
    repeat (6) @(posedge clk);
    chk("pfhold", r0, n_rd);
    do_ret();
    repeat (15) @(posedge clk);
    chk("pfgo", {r0 + 1, 32'd0}, {n_rd, q_in.size()});
    // unretired stores fill the buffer: ready drops, nothing drains
    r0 = n_dc;
    for (i = 0; i < SB_DEPTH; i++)
    begin
      s = '{a + 32'(i * 64), SZ_DWORD, {$random(seed), $random(seed)}, 1'b0};
      do_st(s);
    end
    @(posedge clk);
    chk("stfull", {r0, 1'b0}, {n_dc, st_rdy});
    repeat (SB_DEPTH) do_ret();
    repeat (5) @(posedge clk);
    chk("stfree", {r0 + SB_DEPTH, 1'b1}, {n_dc, st_rdy});
    end_sim();
  end
endmodule
`default_nettype wire
